// ### slpm_params.svh
// Constants for the low-power mode control of the memory link.
// Behaviour
// - Clock enable low enters power-down, only when idle.
// - Idle banks: precharge power-down; open row: active.
// - Power-down disables buffers, keeps clock and enable.
// - Controller holds enable low; device ignores inputs.
// - Controller stays down at least tCKE, refresh-bounded.
// - Enable sampled high exits, with NOP or DESELECT.
// - Controller waits tXP before valid commands.
// - Deepest sleep loses array and mode registers.
// - Burst-terminate with enable low enters deepest sleep.
// - Controller idles banks and bus before deepest sleep.
// - Controller holds enable constantly low in deepest sleep.
// - Exit: stable clock, raise enable, NOPs 200 us.
// - Then rerun initialization steps 4 through 11; the controller issues only a precharge.
// - Clock stop only after last command completes.
// - Clock stop needs timings met, enable high.
// - Clock stop parks true low, complement high.
// - Restart clock with NOP before any access.
// - Access followed by NOPs until its last pulse.
// - Power-down stays keep 64 ms refresh window.
`ifndef SLPM_PARAMS_SVH
`define SLPM_PARAMS_SVH
`define SLPM_CLK_PERIOD_NS 40
`define SLPM_TCKE_NS 80
`define SLPM_TXP_NS 80
`define SLPM_DSLEEP_EXIT_US 200
`define SLPM_REFRESH_WINDOW_MS 64
`define SLPM_TCKE_CYC ((`SLPM_TCKE_NS + `SLPM_CLK_PERIOD_NS - 1) / `SLPM_CLK_PERIOD_NS)
`define SLPM_TXP_CYC ((`SLPM_TXP_NS + `SLPM_CLK_PERIOD_NS - 1) / `SLPM_CLK_PERIOD_NS)
`define SLPM_DSLEEP_EXIT_CYC ((`SLPM_DSLEEP_EXIT_US * 1000 + `SLPM_CLK_PERIOD_NS - 1) / `SLPM_CLK_PERIOD_NS)
`define SLPM_REFRESH_WINDOW_CYC (`SLPM_REFRESH_WINDOW_MS * 1000000 / `SLPM_CLK_PERIOD_NS)
`define SLPM_MAX_STAY_CYC 4000
`define SLPM_CNT_W 24
`define SLPM_CMD_NOP 3'h7
`define SLPM_CMD_ACT 3'h3
`define SLPM_CMD_RD 3'h5
`define SLPM_CMD_WR 3'h4
`define SLPM_CMD_BST 3'h6
`define SLPM_CMD_PRE 3'h2
`endif

// ### slpm_pkg.sv
// Types shared by both ends of the low-power mode link.
package slpm_pkg;
    typedef enum logic [5:0] {
        SLPM_ACTIVE = 6'h01,
        SLPM_PRE_PD = 6'h02,
        SLPM_ACT_PD = 6'h04,
        SLPM_DEEPEST_SLEEP = 6'h08,
        SLPM_CLK_STOP = 6'h10,
        SLPM_UNINIT = 6'h20
    } slpm_dev_state_t;
    typedef enum logic [6:0] {
        SLPC_RUN = 7'h01,
        SLPC_PD = 7'h02,
        SLPC_PD_EXIT = 7'h04,
        SLPC_DSLEEP = 7'h08,
        SLPC_DSLEEP_EXIT = 7'h10,
        SLPC_STOPPED = 7'h20,
        SLPC_RESTART = 7'h40
    } slpm_ctl_state_t;
endpackage

// ### slpm_link_if.sv
// Link between the memory controller and the device low-power logic.
`timescale 1ns/1ps
interface slpm_link_if;
    logic clkEnable;
    logic clockRun;
    logic clockTrue;
    logic clockComp;
    logic [2:0] command;
    modport controller (output clkEnable, output clockRun, output clockTrue, output clockComp, output command);
    modport device (input clkEnable, input clockRun, input clockTrue, input clockComp, input command);
endinterface

// ### slpm_device.sv
// Device end: tracks power-down, deepest sleep and clock stop.
`timescale 1ns/1ps
`include "slpm_params.svh"
module slpm_device
    import slpm_pkg::*;
(
    // Clock and reset.
    input wire logic clock,
    input wire logic reset,
    // Link.
    slpm_link_if.device link,
    // User side.
    input wire logic bankOpen,
    output logic buffersEnabled,
    output logic commandValid,
    output logic [2:0] commandOut,
    output logic contentsValid,
    output slpm_dev_state_t state
);
    slpm_dev_state_t next_state;
    slpm_dev_state_t resume;
    slpm_dev_state_t next_resume;
    logic next_buffersEnabled;
    logic next_commandValid;
    logic [2:0] next_commandOut;
    logic next_contentsValid;
    logic cmdIsNop;

    assign cmdIsNop = (link.command == `SLPM_CMD_NOP);

    always_comb begin
        next_state = state;
        next_resume = resume;
        next_buffersEnabled = buffersEnabled;
        next_commandValid = 1'b0;
        next_commandOut = commandOut;
        next_contentsValid = contentsValid;
        case (state)
            SLPM_ACTIVE, SLPM_UNINIT: begin
                if (!link.clockRun) begin
                    // Clock parked true low, complement high.
                    if (!link.clockTrue && link.clockComp) begin
                        next_resume = state;
                        next_state = SLPM_CLK_STOP;
                    end
                end else if (!link.clkEnable && link.command == `SLPM_CMD_BST) begin
                    next_state = SLPM_DEEPEST_SLEEP;
                    next_buffersEnabled = 1'b0;
                    next_contentsValid = 1'b0;
                end else if (!link.clkEnable) begin
                    next_resume = state;
                    next_state = bankOpen ? SLPM_ACT_PD : SLPM_PRE_PD;
                    next_buffersEnabled = 1'b0;
                end else begin
                    next_commandValid = !cmdIsNop;
                    next_commandOut = link.command;
                end
            end
            SLPM_PRE_PD, SLPM_ACT_PD: begin
                // Exit needs clock running, enable high and a NOP; the open row is simply kept.
                if (link.clockRun && link.clkEnable && cmdIsNop) begin
                    next_state = resume;
                    next_buffersEnabled = 1'b1;
                end
            end
            SLPM_DEEPEST_SLEEP: begin
                // Contents stay invalid until the controller reinitialises.
                if (link.clockRun && link.clkEnable) begin
                    next_state = SLPM_UNINIT;
                    next_buffersEnabled = 1'b1;
                end
            end
            SLPM_CLK_STOP: begin
                if (link.clockRun) begin
                    next_state = resume;
                end
            end
            default: begin
                next_state = SLPM_UNINIT;
            end
        endcase
        // An initialising precharge after deepest sleep restores use.
        if (state == SLPM_UNINIT && link.clockRun && link.clkEnable && link.command == `SLPM_CMD_PRE) begin
            next_contentsValid = 1'b1;
            next_state = SLPM_ACTIVE;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            state <= SLPM_ACTIVE;
            resume <= SLPM_ACTIVE;
            buffersEnabled <= 1'b1;
            commandValid <= 1'b0;
            commandOut <= `SLPM_CMD_NOP;
            contentsValid <= 1'b1;
        end else begin
            state <= next_state;
            resume <= next_resume;
            buffersEnabled <= next_buffersEnabled;
            commandValid <= next_commandValid;
            commandOut <= next_commandOut;
            contentsValid <= next_contentsValid;
        end
    end
endmodule

// ### slpm_controller.sv
// Controller end: sequences power-down, deepest sleep and clock stop.
`timescale 1ns/1ps
`include "slpm_params.svh"
module slpm_controller
    import slpm_pkg::*;
#(
    parameter int DSLEEP_EXIT_CYC = `SLPM_DSLEEP_EXIT_CYC
)
(
    // Clock and reset.
    input wire logic clock,
    input wire logic reset,
    // Link.
    slpm_link_if.controller link,
    // User side.
    input wire logic reqPowerDown,
    input wire logic reqDeepSleep,
    input wire logic reqClockStop,
    input wire logic accessIdle,
    input wire logic userCmdValid,
    input wire logic [2:0] userCmd,
    output logic userCmdReady,
    output logic needInit,
    output slpm_ctl_state_t state
);
    slpm_ctl_state_t next_state;
    logic [`SLPM_CNT_W-1:0] count;
    logic [`SLPM_CNT_W-1:0] next_count;
    logic next_needInit;
    logic [2:0] next_command;
    logic next_clkEnable;
    logic next_clockRun;
    logic [2:0] commandReg;
    logic clkEnableReg;
    logic clockRunReg;
    logic minStayMet;

    assign link.command = commandReg;
    assign link.clkEnable = clkEnableReg;
    assign link.clockRun = clockRunReg;
    // Parked levels while stopped; while running, the true clock follows clock and the complement is its inverse.
    assign link.clockTrue = clockRunReg & clock;
    assign link.clockComp = ~link.clockTrue;
    // The power-down counter starts at the stay cap, so tCKE is met once it has fallen by that much.
    assign minStayMet = count <= `SLPM_CNT_W'(`SLPM_MAX_STAY_CYC - `SLPM_TCKE_CYC);

    always_comb begin
        next_state = state;
        next_count = (count != '0) ? count - 1'b1 : count;
        next_needInit = needInit;
        next_command = `SLPM_CMD_NOP;
        next_clkEnable = clkEnableReg;
        next_clockRun = clockRunReg;
        userCmdReady = 1'b0;
        case (state)
            SLPC_RUN: begin
                userCmdReady = (count == '0) && !needInit;
                if (reqDeepSleep && accessIdle && count == '0) begin
                    next_command = `SLPM_CMD_BST;
                    next_clkEnable = 1'b0;
                    next_needInit = 1'b1;
                    next_state = SLPC_DSLEEP;
                end else if (reqPowerDown && accessIdle && count == '0) begin
                    next_clkEnable = 1'b0;
                    // One counter times both the minimum stay and the refresh cap.
                    next_count = `SLPM_CNT_W'(`SLPM_MAX_STAY_CYC);
                    next_state = SLPC_PD;
                end else if (reqClockStop && accessIdle && count == '0 && clkEnableReg) begin
                    next_clockRun = 1'b0;
                    next_state = SLPC_STOPPED;
                end else if (userCmdValid && userCmdReady) begin
                    next_command = userCmd;
                end
            end
            SLPC_PD: begin
                // The stay is capped so refresh can still be served.
                if ((!reqPowerDown && minStayMet) || count == '0) begin
                    next_clkEnable = 1'b1;
                    next_count = `SLPM_CNT_W'(`SLPM_TXP_CYC);
                    next_state = SLPC_RUN;
                end
            end
            SLPC_DSLEEP: begin
                if (!reqDeepSleep) begin
                    next_clkEnable = 1'b1;
                    next_count = `SLPM_CNT_W'(DSLEEP_EXIT_CYC);
                    next_state = SLPC_DSLEEP_EXIT;
                end
            end
            SLPC_DSLEEP_EXIT: begin
                if (count == '0) begin
                    // Reinitialisation begins with a precharge-all.
                    next_command = `SLPM_CMD_PRE;
                    next_needInit = 1'b0;
                    next_state = SLPC_RUN;
                end
            end
            SLPC_STOPPED: begin
                if (!reqClockStop) begin
                    next_clockRun = 1'b1;
                    next_state = SLPC_RESTART;
                end
            end
            SLPC_RESTART: begin
                next_state = SLPC_RUN;
            end
            default: begin
                next_state = SLPC_RUN;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            state <= SLPC_RUN;
            count <= '0;
            needInit <= 1'b0;
            commandReg <= `SLPM_CMD_NOP;
            clkEnableReg <= 1'b1;
            clockRunReg <= 1'b1;
        end else begin
            state <= next_state;
            count <= next_count;
            needInit <= next_needInit;
            commandReg <= next_command;
            clkEnableReg <= next_clkEnable;
            clockRunReg <= next_clockRun;
        end
    end
endmodule

// ### slpm_link_asserts.sv
// Concurrent checks on the low-power link between controller and device.
`timescale 1ns/1ps
`include "slpm_params.svh"
module slpm_link_asserts #(
    parameter int DSLEEP_EXIT_CYC = 8
)(
    // Clock and reset.
    input wire logic clock,
    input wire logic reset,
    // Link.
    input wire logic clkEnable,
    input wire logic clockRun,
    input wire logic clockTrue,
    input wire logic clockComp,
    input wire logic [2:0] command
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    logic deep;
    int nopCount;
    // Counts cycles of raised enable after deepest sleep, until the first real command.
    always_ff @(posedge clock) begin
        if (reset) begin
            deep <= 1'b0;
            nopCount <= 0;
        end else if (!clkEnable && command == `SLPM_CMD_BST) begin
            deep <= 1'b1;
            nopCount <= 0;
        end else if (deep && clkEnable) begin
            deep <= (command == `SLPM_CMD_NOP);
            nopCount <= nopCount + 1;
        end
    end
    property p_pair; !clockRun |-> clkEnable && command == `SLPM_CMD_NOP; endproperty
    a_pair: assert property (p_pair) else $error("clock stopped without enable high and idle command");
    property p_park; !clockRun |-> !clockTrue && clockComp; endproperty
    a_park: assert property (p_park) else $error("stopped clock not parked");
    property p_stop; $fell(clockRun) |-> clkEnable && command == `SLPM_CMD_NOP; endproperty
    a_stop: assert property (p_stop) else $error("clock stopped while busy");
    property p_restart; $rose(clockRun) |-> command == `SLPM_CMD_NOP; endproperty
    a_restart: assert property (p_restart) else $error("restart without idle command");
    property p_txp; $rose(clkEnable) |-> (command == `SLPM_CMD_NOP) [*2]; endproperty
    a_txp: assert property (p_txp) else $error("command too soon after exit");
    property p_tcke; $fell(clkEnable) |-> !clkEnable [*2]; endproperty
    a_tcke: assert property (p_tcke) else $error("power-down too short");
    property p_quiet; !clkEnable && !$past(clkEnable) |-> command == `SLPM_CMD_NOP; endproperty
    a_quiet: assert property (p_quiet) else $error("command during power-down");
    property p_entry; !clkEnable && command == `SLPM_CMD_BST |-> $fell(clkEnable); endproperty
    a_entry: assert property (p_entry) else $error("deepest sleep entry malformed");
    property p_wait; deep && clkEnable && command != `SLPM_CMD_NOP |-> nopCount >= DSLEEP_EXIT_CYC; endproperty
    a_wait: assert property (p_wait) else $error("reinit before exit wait");
endmodule

// ### slpm_tb.sv
// Self-checking bench for both ends of the low-power link.
`timescale 1ns/1ps
`include "slpm_params.svh"
module slpm_tb
    import slpm_pkg::*;
;
    // Short exit wait keeps the run brief; the checker gets the same value.
    localparam int EXIT = 8;
    logic clock = 1'b0, reset = 1'b1, bankOpen = 1'b0, accessIdle = 1'b1;
    logic reqPowerDown = 1'b0, reqDeepSleep = 1'b0, reqClockStop = 1'b0, userCmdValid = 1'b0;
    logic [2:0] userCmd = `SLPM_CMD_NOP;
    logic buffersEnabled, commandValid, contentsValid, userCmdReady, needInit;
    logic [2:0] commandOut;
    slpm_dev_state_t devState;
    slpm_ctl_state_t ctlState;
    int n_mismatch = 0, n_compared = 0, cycles = 0;
    slpm_link_if link();
    slpm_device slpm_device_i (.clock(clock), .reset(reset), .link(link), .bankOpen(bankOpen),
        .buffersEnabled(buffersEnabled), .commandValid(commandValid), .commandOut(commandOut),
        .contentsValid(contentsValid), .state(devState));
    slpm_controller #(.DSLEEP_EXIT_CYC(EXIT)) slpm_controller_i (.clock(clock), .reset(reset),
        .link(link), .reqPowerDown(reqPowerDown), .reqDeepSleep(reqDeepSleep), .reqClockStop(reqClockStop),
        .accessIdle(accessIdle), .userCmdValid(userCmdValid), .userCmd(userCmd),
        .userCmdReady(userCmdReady), .needInit(needInit), .state(ctlState));
    slpm_link_asserts #(.DSLEEP_EXIT_CYC(EXIT)) slpm_link_asserts_i (.clock(clock), .reset(reset),
        .clkEnable(link.clkEnable), .clockRun(link.clockRun), .clockTrue(link.clockTrue),
        .clockComp(link.clockComp), .command(link.command));
    initial begin
        forever #20 clock = ~clock;
    end
    // The capped power-down stay takes about four thousand cycles; a hang is cut well beyond the whole run.
    always @(posedge clock) begin
        cycles++;
        if (cycles == 6000) begin
            n_mismatch++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        if (n_mismatch == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wait_dev(input slpm_dev_state_t exp);
        for (int i = 0; i < 40 && devState !== exp; i++) @(negedge clock);
        chk({2'h0, devState}, {2'h0, exp});
    endtask
    // Holds the request until ready is seen, then expects it at the device side.
    task automatic send(input logic [2:0] c);
        userCmd = c;
        userCmdValid = 1'b1;
        for (int i = 0; i < 20 && userCmdReady !== 1'b1; i++) @(negedge clock);
        @(negedge clock);
        userCmdValid = 1'b0;
        for (int i = 0; i < 6 && commandValid !== 1'b1; i++) @(negedge clock);
        chk({4'h0, commandValid, commandOut}, {4'h0, 1'b1, c});
    endtask
    initial begin
        repeat (6) @(negedge clock);
        reset = 1'b0;
        @(negedge clock);
        wait_dev(SLPM_ACTIVE);
        chk({5'h0, buffersEnabled, contentsValid, needInit}, 8'h06);
        send(`SLPM_CMD_ACT);
        send(`SLPM_CMD_WR);
        send(`SLPM_CMD_RD);
        send(`SLPM_CMD_PRE);
        accessIdle = 1'b0;
        reqPowerDown = 1'b1;
        repeat (4) @(negedge clock);
        chk({1'b0, ctlState}, {1'b0, SLPC_RUN});
        accessIdle = 1'b1;
        wait_dev(SLPM_PRE_PD);
        chk({7'h0, buffersEnabled}, 8'h00);
        reqPowerDown = 1'b0;
        wait_dev(SLPM_ACTIVE);
        chk({7'h0, buffersEnabled}, 8'h01);
        chk({7'h0, userCmdReady}, 8'h00);
        send(`SLPM_CMD_ACT);
        bankOpen = 1'b1;
        reqPowerDown = 1'b1;
        wait_dev(SLPM_ACT_PD);
        reqPowerDown = 1'b0;
        wait_dev(SLPM_ACTIVE);
        send(`SLPM_CMD_PRE);
        bankOpen = 1'b0;
        reqPowerDown = 1'b1;
        wait_dev(SLPM_PRE_PD);
        repeat (3990) @(negedge clock);
        chk({2'h0, devState}, {2'h0, SLPM_PRE_PD});
        wait_dev(SLPM_ACTIVE);
        reqPowerDown = 1'b0;
        reqDeepSleep = 1'b1;
        wait_dev(SLPM_DEEPEST_SLEEP);
        chk({7'h0, contentsValid}, 8'h00);
        reqDeepSleep = 1'b0;
        wait_dev(SLPM_ACTIVE);
        chk({6'h0, contentsValid, needInit}, 8'h02);
        reqClockStop = 1'b1;
        wait_dev(SLPM_CLK_STOP);
        chk({5'h0, link.clockRun, link.clockTrue, link.clockComp}, 8'h01);
        reqClockStop = 1'b0;
        wait_dev(SLPM_ACTIVE);
        send(`SLPM_CMD_RD);
        report_and_stop();
    end
endmodule
